// File: shared/aspc_pkg.sv
package aspc_pkg;

  // register word width and bus widths
  localparam int          REG_W     = 8;
  localparam int          DATA_W    = 32;
  localparam int          ADDR_W    = 8;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0]  IDX_SLOT3 = 8'h08;
  localparam logic [7:0]  IDX_SLOT4 = 8'h09;
  localparam logic [7:0]  IDX_SLOT5 = 8'h0a;
  localparam logic [7:0]  ADDR_SLOT3 = {IDX_SLOT3[5:0], 2'b00};
  localparam logic [7:0]  ADDR_SLOT4 = {IDX_SLOT4[5:0], 2'b00};
  localparam logic [7:0]  ADDR_SLOT5 = {IDX_SLOT5[5:0], 2'b00};

  // reset values
  localparam logic [7:0]  RST_SLOT3 = 8'h32;
  localparam logic [7:0]  RST_SLOT4 = 8'h07;
  localparam logic [7:0]  RST_SLOT5 = 8'h07;

  // field positions
  localparam int          PLAY_HI   = 5;
  localparam int          PLAY_LO   = 4;
  localparam int          PLAY_SKIP = 5;
  localparam int          SNS_HI    = 2;
  localparam int          SNS_LO    = 0;
  localparam int          MARK_BIT  = 7;

  // playback width codes; any code with the top bit set skips 8 bits
  localparam logic [1:0]  PLAY_24   = 2'h0;
  localparam logic [1:0]  PLAY_16   = 2'h1;

  // bit counts carried on the slot
  localparam logic [4:0]  BITS_0    = 5'h00;
  localparam logic [4:0]  BITS_8    = 5'h08;
  localparam logic [4:0]  BITS_16   = 5'h10;
  localparam logic [4:0]  BITS_24   = 5'h18;

  // placement numbers
  localparam logic [2:0]  PLACE_NONE = 3'h0;
  localparam logic [2:0]  PLACE3    = 3'h3;
  localparam logic [2:0]  PLACE4    = 3'h4;
  localparam logic [2:0]  PLACE5    = 3'h5;

  // sense output choices
  typedef enum logic [2:0] {
    SNS_VOLT  = 3'h0,
    SNS_CURR  = 3'h1,
    SNS_VBAT  = 3'h2,
    SNS_CTRL  = 3'h3,
    SNS_ALT   = 3'h4,
    SNS_STAT  = 3'h5,
    SNS_MARK  = 3'h6,
    SNS_BLANK = 3'h7
  } aspc_sense_t;

endpackage : aspc_pkg

// File: verilog/aspc_slot_decode.sv
`timescale 1ns/10ps
`default_nettype none
module aspc_slot_decode
  import aspc_pkg::*;
#(
  parameter bit HAS_PLAY = 1'b1
) (
  input  wire logic [7:0]  i_ctrl,
  input  wire logic [2:0]  i_slot_id,
  input  wire logic        i_alt_phase,
  input  wire logic [15:0] i_volt,
  input  wire logic [15:0] i_curr,
  input  wire logic [7:0]  i_vbat,
  input  wire logic [7:0]  i_ctrl_data,
  input  wire logic [7:0]  i_status,
  output logic             o_play_skip,
  output logic [4:0]       o_play_bits,
  output logic [15:0]      o_tx_word,
  output logic [4:0]       o_tx_bits,
  output logic             o_tx_current
);
  import aspc_pkg::*;

  // playback width from the two-bit field; reserved bits never looked at
  function automatic logic [4:0] play_bits(input logic [1:0] code);
    if (code[1]) begin
      play_bits = BITS_8;
    end else if (code == PLAY_16) begin
      play_bits = BITS_16;
    end else begin
      play_bits = BITS_24;
    end
  endfunction : play_bits

  wire aspc_sense_t sel      = aspc_sense_t'(i_ctrl[SNS_HI:SNS_LO]);
  wire logic [1:0]  play_fld = i_ctrl[PLAY_HI:PLAY_LO];
  // alternation starts on voltage, then current on the next frame
  wire logic        alt_cur  = (sel == SNS_ALT) && i_alt_phase;
  wire logic        is_cur   = (sel == SNS_CURR) || alt_cur;
  wire logic [7:0]  marker   = {i_alt_phase, 4'h0, i_slot_id};

  // playback: a slot without a playback field always passes on
  assign o_play_skip  = HAS_PLAY ? play_fld[1] : 1'b1;
  assign o_play_bits  = HAS_PLAY ? play_bits(play_fld) : BITS_0;
  assign o_tx_current = is_cur;

  // sense word and its length on the slot
  always_comb begin
    o_tx_word = 16'h0000;
    o_tx_bits = BITS_8;
    case (sel)
      SNS_VOLT: begin
        o_tx_word = i_volt;
        o_tx_bits = BITS_16;
      end
      SNS_CURR: begin
        o_tx_word = i_curr;
        o_tx_bits = BITS_16;
      end
      SNS_VBAT:  o_tx_word = {8'h00, i_vbat};
      SNS_CTRL:  o_tx_word = {8'h00, i_ctrl_data};
      SNS_ALT: begin
        o_tx_word = alt_cur ? i_curr : i_volt;
        o_tx_bits = BITS_16;
      end
      SNS_STAT:  o_tx_word = {8'h00, i_status};
      SNS_MARK:  o_tx_word = {8'h00, marker};
      SNS_BLANK: o_tx_word = 16'h0000;
      default:   o_tx_word = 16'h0000;
    endcase
  end

endmodule : aspc_slot_decode
`default_nettype wire

// File: verilog/aspc_top.sv
// Operation
// - slot 3 playback field bits 5:4: 00 takes 24 bits, 01 takes 16.
// - slot 3 playback 10 or 11 skips 8 bits; audio comes from slot 4 unless it skips too.
// - slot 4 has its own playback field with identical coding.
// - sense select bits 2:0: 000 sends 16-bit voltage, 001 16-bit current.
// - select 010 sends 8-bit battery voltage, 011 8-bit control data.
// - select 100 alternates 16-bit voltage and current samples per frame.
// - 101 sends status, 110 marker with slot id, 111 eight blank bits.
// - slot 4 has a three-bit sense select with the same eight choices.
// - slot 5 has only a sense select; bits 7:3 reserved, no playback.
// - slot 3 register resets to 0x32: skip playback, battery output.
// - slot 4 register resets to 0x07: 24-bit playback, blank output.
// - slot 5 register resets to 0x07: blank output until reprogrammed.
`timescale 1ns/10ps
`default_nettype none
module aspc_top (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst,
  // apb slave
  input  wire logic [aspc_pkg::ADDR_W-1:0] i_paddr,
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [aspc_pkg::DATA_W-1:0] i_pwdata,
  input  wire logic [3:0]             i_pstrb,
  output logic                        o_pready,
  output logic [aspc_pkg::DATA_W-1:0] o_prdata,
  output logic                        o_pslverr,
  // frame and sample inputs
  input  wire logic                   i_frame_strobe,
  input  wire logic [15:0]            i_volt,
  input  wire logic [15:0]            i_curr,
  input  wire logic [7:0]             i_vbat,
  input  wire logic [7:0]             i_ctrl_data,
  input  wire logic [7:0]             i_status,
  // received slot words
  input  wire logic                   i_rx_valid,
  input  wire logic [2:0]             i_rx_place,
  input  wire logic [23:0]            i_rx_data,
  // playback result
  output logic [2:0]                  o_play_place,
  output logic [4:0]                  o_play_bits,
  output logic [23:0]                 o_play_word,
  output logic                        o_play_valid,
  // sense words per slot
  output logic [15:0]                 o_slot3_tx_word,
  output logic [4:0]                  o_slot3_tx_bits,
  output logic                        o_slot3_tx_current,
  output logic [15:0]                 o_slot4_tx_word,
  output logic [4:0]                  o_slot4_tx_bits,
  output logic                        o_slot4_tx_current,
  output logic [15:0]                 o_slot5_tx_word,
  output logic [4:0]                  o_slot5_tx_bits,
  output logic                        o_slot5_tx_current
);
  import aspc_pkg::*;

  localparam int NSLOT = 3;

  // which of the three registers an address hits
  function automatic logic [2:0] reg_hit(input logic [ADDR_W-1:0] addr);
    reg_hit = {addr == ADDR_SLOT5, addr == ADDR_SLOT4, addr == ADDR_SLOT3};
  endfunction : reg_hit

  // control registers
  logic [7:0]  slot3_placement_ctrl_reg;
  logic [7:0]  slot4_placement_ctrl_reg;
  logic [7:0]  slot5_placement_ctrl_reg;
  logic [DATA_W-1:0] prdata_reg;

  // per-slot alternation phase and registered sense words
  logic [NSLOT-1:0] alt_phase_reg;
  logic [NSLOT-1:0] alt_phase_next;
  logic [15:0] tx_word_reg [NSLOT];
  logic [4:0]  tx_bits_reg [NSLOT];
  logic [NSLOT-1:0] tx_cur_reg;

  // playback state
  logic [2:0]  play_place_reg;
  logic [4:0]  play_bits_reg;
  logic [23:0] play_word_reg;
  logic        play_valid_reg;

  // decoder results
  logic [7:0]  ctrl_arr  [NSLOT];
  logic [2:0]  slot_id   [NSLOT];
  logic [NSLOT-1:0] dec_skip;
  logic [4:0]  dec_pbits [NSLOT];
  logic [15:0] dec_word  [NSLOT];
  logic [4:0]  dec_tbits [NSLOT];
  logic [NSLOT-1:0] dec_cur;

  // bus decode; zero wait states so pready stays high
  wire logic [2:0] hit      = reg_hit(i_paddr);
  wire logic       mapped   = |hit;
  wire logic       apb_acc  = i_psel && i_penable;
  wire logic       apb_set  = i_psel && !i_penable;
  wire logic       apb_wr   = apb_acc && i_pwrite && mapped && i_pstrb[0];
  wire logic [7:0] wbyte    = i_pwdata[7:0];

  assign o_pready  = 1'b1;
  assign o_pslverr = apb_acc && !mapped;
  assign o_prdata  = prdata_reg;

  // read word picked in the setup phase so prdata comes from a flop
  wire logic [7:0] rd_byte = hit[0] ? slot3_placement_ctrl_reg :
                             hit[1] ? slot4_placement_ctrl_reg :
                             hit[2] ? slot5_placement_ctrl_reg : 8'h00;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (apb_set && !i_pwrite) begin
      prdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  // register writes; all eight bits stored, reserved bits included
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      slot3_placement_ctrl_reg <= RST_SLOT3;
      slot4_placement_ctrl_reg <= RST_SLOT4;
      slot5_placement_ctrl_reg <= RST_SLOT5;
    end else if (apb_wr) begin
      if (hit[0]) begin
        slot3_placement_ctrl_reg <= wbyte;
      end
      if (hit[1]) begin
        slot4_placement_ctrl_reg <= wbyte;
      end
      if (hit[2]) begin
        slot5_placement_ctrl_reg <= wbyte;
      end
    end
  end

  // decoder inputs per slot
  assign ctrl_arr[0] = slot3_placement_ctrl_reg;
  assign ctrl_arr[1] = slot4_placement_ctrl_reg;
  assign ctrl_arr[2] = slot5_placement_ctrl_reg;
  assign slot_id[0]  = PLACE3;
  assign slot_id[1]  = PLACE4;
  assign slot_id[2]  = PLACE5;

  // one decoder per slot; slot 5 carries no playback field
  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    aspc_slot_decode #(
      .HAS_PLAY (s < 2)
    ) u_dec (
      .i_ctrl       (ctrl_arr[s]),
      .i_slot_id    (slot_id[s]),
      .i_alt_phase  (alt_phase_reg[s]),
      .i_volt       (i_volt),
      .i_curr       (i_curr),
      .i_vbat       (i_vbat),
      .i_ctrl_data  (i_ctrl_data),
      .i_status     (i_status),
      .o_play_skip  (dec_skip[s]),
      .o_play_bits  (dec_pbits[s]),
      .o_tx_word    (dec_word[s]),
      .o_tx_bits    (dec_tbits[s]),
      .o_tx_current (dec_cur[s])
    );

    // phase flips once per frame only while alternating
    assign alt_phase_next[s] =
      (ctrl_arr[s][SNS_HI:SNS_LO] != SNS_ALT) ? 1'b0 :
      i_frame_strobe ? !alt_phase_reg[s] : alt_phase_reg[s];
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      alt_phase_reg <= '0;
    end else begin
      alt_phase_reg <= alt_phase_next;
    end
  end

  // sense words registered each cycle; slot 5 is the last in the array
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      for (int s = 0; s < NSLOT; s++) begin
        tx_word_reg[s] <= 16'h0000;
        tx_bits_reg[s] <= BITS_8;
      end
      tx_cur_reg <= '0;
    end else begin
      for (int s = 0; s < NSLOT; s++) begin
        tx_word_reg[s] <= dec_word[s];
        tx_bits_reg[s] <= dec_tbits[s];
      end
      tx_cur_reg <= dec_cur;
    end
  end

  assign o_slot3_tx_word    = tx_word_reg[0];
  assign o_slot3_tx_bits    = tx_bits_reg[0];
  assign o_slot3_tx_current = tx_cur_reg[0];
  assign o_slot4_tx_word    = tx_word_reg[1];
  assign o_slot4_tx_bits    = tx_bits_reg[1];
  assign o_slot4_tx_current = tx_cur_reg[1];
  assign o_slot5_tx_word    = tx_word_reg[2];
  assign o_slot5_tx_bits    = tx_bits_reg[2];
  assign o_slot5_tx_current = tx_cur_reg[2];

  // audio placement: slot 3 unless it skips, then slot 4 unless that
  // skips too; with both skipping no playback word is taken at all
  wire logic [2:0] place_next =
    !dec_skip[0] ? PLACE3 :
    !dec_skip[1] ? PLACE4 : PLACE_NONE;
  wire logic [4:0] bits_next =
    !dec_skip[0] ? dec_pbits[0] :
    !dec_skip[1] ? dec_pbits[1] : BITS_0;

  // 16-bit words sit in the top of the slot; low byte masked off
  wire logic       take_rx  = i_rx_valid && (play_place_reg != PLACE_NONE) &&
                              (i_rx_place == play_place_reg);
  wire logic [23:0] rx_mask =
    (play_bits_reg == BITS_16) ? 24'hff_ff00 : 24'hff_ffff;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      play_place_reg <= PLACE4;
      play_bits_reg  <= BITS_24;
      play_word_reg  <= 24'h00_0000;
      play_valid_reg <= 1'b0;
    end else begin
      play_place_reg <= place_next;
      play_bits_reg  <= bits_next;
      play_valid_reg <= take_rx;
      if (take_rx) begin
        play_word_reg <= i_rx_data & rx_mask;
      end
    end
  end

  assign o_play_place = play_place_reg;
  assign o_play_bits  = play_bits_reg;
  assign o_play_word  = play_word_reg;
  assign o_play_valid = play_valid_reg;

  // checks on the behaviour above
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  play_width3_a: assert property (
    (slot3_placement_ctrl_reg[PLAY_HI:PLAY_LO] == PLAY_24)
    |=> (o_play_place == PLACE3) && (o_play_bits == BITS_24))
    else $error("slot 3 24-bit playback not selected");

  play_skip3_a: assert property (
    slot3_placement_ctrl_reg[PLAY_SKIP] && !slot4_placement_ctrl_reg[PLAY_SKIP]
    |=> (o_play_place == PLACE4))
    else $error("slot 3 skip did not move audio to slot 4");

  play_width4_a: assert property (
    slot3_placement_ctrl_reg[PLAY_SKIP] &&
    (slot4_placement_ctrl_reg[PLAY_HI:PLAY_LO] == PLAY_16)
    |=> (o_play_bits == BITS_16))
    else $error("slot 4 16-bit playback width wrong");

  sense_volt_a: assert property (
    (slot3_placement_ctrl_reg[SNS_HI:SNS_LO] == SNS_VOLT)
    |=> (o_slot3_tx_word == $past(i_volt)) && (o_slot3_tx_bits == BITS_16))
    else $error("slot 3 voltage word wrong");

  sense_vbat_a: assert property (
    !i_rst && (slot3_placement_ctrl_reg[SNS_HI:SNS_LO] == SNS_VBAT)
    |=> (o_slot3_tx_word == {8'h00, $past(i_vbat)}) &&
        (o_slot3_tx_bits == BITS_8))
    else $error("slot 3 battery word wrong");

  sense_alt_a: assert property (
    (slot4_placement_ctrl_reg[SNS_HI:SNS_LO] == SNS_ALT) && i_frame_strobe
    ##1 (slot4_placement_ctrl_reg[SNS_HI:SNS_LO] == SNS_ALT)
    |=> (o_slot4_tx_current != $past(o_slot4_tx_current)))
    else $error("slot 4 alternation did not flip");

  sense_blank_a: assert property (
    (slot5_placement_ctrl_reg[SNS_HI:SNS_LO] == SNS_BLANK)
    |=> (o_slot5_tx_word == 16'h0000) && (o_slot5_tx_bits == BITS_8))
    else $error("slot 5 blank output wrong");

  marker_id4_a: assert property (
    (slot4_placement_ctrl_reg[SNS_HI:SNS_LO] == SNS_MARK)
    |=> (o_slot4_tx_word[2:0] == PLACE4) && (o_slot4_tx_bits == BITS_8))
    else $error("slot 4 marker id wrong");

  reset_vals_a: assert property (
    $past(i_rst) && !$past(apb_wr)
    |-> (slot3_placement_ctrl_reg == RST_SLOT3) &&
        (slot4_placement_ctrl_reg == RST_SLOT4) &&
        (slot5_placement_ctrl_reg == RST_SLOT5))
    else $error("placement registers not at reset values");

  write_store_a: assert property (
    apb_wr && hit[2]
    |=> (slot5_placement_ctrl_reg == $past(wbyte)))
    else $error("slot 5 write not stored in full");

endmodule : aspc_top
`default_nettype wire

// File: test/aspc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module aspc_host_model (
  input  wire logic        i_clk_sys,
  output logic             o_frame_strobe,
  output logic             o_rx_valid,
  output logic [2:0]       o_rx_place,
  output logic [23:0]      o_rx_data
);
  // quiet lines at time zero
  initial begin
    o_frame_strobe = 1'b0;
    o_rx_valid     = 1'b0;
    o_rx_place     = 3'h0;
    o_rx_data      = 24'h00_0000;
  end

  // one slot word per call; gap lets the host answer late
  task automatic send(input logic [2:0] pl, input logic [23:0] d,
                      input int gap);
    // launch right after an edge, never mid-cycle
    @(posedge i_clk_sys);
    repeat (gap) @(posedge i_clk_sys);
    o_rx_valid <= 1'b1;
    o_rx_place <= pl;
    o_rx_data  <= d;
    @(posedge i_clk_sys);
    o_rx_valid <= 1'b0;
    // released lines carry junk so a stale word never looks right
    o_rx_place <= ~pl;
    o_rx_data  <= ~d;
  endtask : send

  // one-cycle frame boundary pulse
  task automatic frame;
    @(posedge i_clk_sys);
    o_frame_strobe <= 1'b1;
    @(posedge i_clk_sys);
    o_frame_strobe <= 1'b0;
  endtask : frame
endmodule : aspc_host_model
`default_nettype wire

// File: test/tb_audio_slot_placement_config.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) \
  begin \
    n_checks++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("BAD %0t got %h exp %h", $time, (g), (e)); \
    end \
  end
module tb_audio_slot_placement_config;
  import aspc_pkg::*;
  logic             i_clk_sys = 1'b0, i_rst = 1'b1;
  logic             i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0]       i_paddr = 8'h00;
  logic [31:0]      i_pwdata = 32'h0000_0000;
  logic [3:0]       i_pstrb = 4'h0;
  logic [15:0]      i_volt = 16'h1a2b, i_curr = 16'h3c4d;
  logic [7:0]       i_vbat = 8'h9c, i_ctrl_data = 8'h5e, i_status = 8'h6f;
  wire logic        i_frame_strobe, i_rx_valid;
  wire logic [2:0]  i_rx_place;
  wire logic [23:0] i_rx_data;
  logic             o_pready, o_pslverr, o_play_valid;
  logic [31:0]      o_prdata;
  logic [2:0]       o_play_place;
  logic [4:0]       o_play_bits, o_slot3_tx_bits;
  logic [4:0]       o_slot4_tx_bits, o_slot5_tx_bits;
  logic [23:0]      o_play_word;
  logic [15:0]      o_slot3_tx_word, o_slot4_tx_word, o_slot5_tx_word;
  logic             o_slot3_tx_current, o_slot4_tx_current;
  logic             o_slot5_tx_current;
  int               fails = 0, n_checks = 0;

  // 125 MHz system clock
  always #4 i_clk_sys = ~i_clk_sys;

  aspc_top i_dut (
    .i_clk_sys, .i_rst, .i_paddr, .i_psel, .i_penable, .i_pwrite,
    .i_pwdata, .i_pstrb, .o_pready, .o_prdata, .o_pslverr,
    .i_frame_strobe, .i_volt, .i_curr, .i_vbat, .i_ctrl_data, .i_status,
    .i_rx_valid, .i_rx_place, .i_rx_data, .o_play_place, .o_play_bits,
    .o_play_word, .o_play_valid, .o_slot3_tx_word, .o_slot3_tx_bits,
    .o_slot3_tx_current, .o_slot4_tx_word, .o_slot4_tx_bits,
    .o_slot4_tx_current, .o_slot5_tx_word, .o_slot5_tx_bits,
    .o_slot5_tx_current
  );

  aspc_host_model i_host (
    .i_clk_sys, .o_frame_strobe(i_frame_strobe), .o_rx_valid(i_rx_valid),
    .o_rx_place(i_rx_place), .o_rx_data(i_rx_data)
  );

  function automatic logic [7:0] addr_of(input int s);
    return (s == 3) ? ADDR_SLOT3 : (s == 4) ? ADDR_SLOT4 : ADDR_SLOT5;
  endfunction : addr_of

  // expected {current flag, bit count, word} for one sense choice
  function automatic logic [21:0] exp_tx(input logic [2:0] c,
                                         input logic [2:0] id,
                                         input logic ph);
    case (c)
      3'h0: return {1'b0, BITS_16, i_volt};
      3'h1: return {1'b1, BITS_16, i_curr};
      3'h2: return {1'b0, BITS_8, 8'h00, i_vbat};
      3'h3: return {1'b0, BITS_8, 8'h00, i_ctrl_data};
      3'h4: return ph ? {1'b1, BITS_16, i_curr} : {1'b0, BITS_16, i_volt};
      3'h5: return {1'b0, BITS_8, 8'h00, i_status};
      3'h6: return {1'b0, BITS_8, 8'h00, ph, 4'h0, id};
      default: return {1'b0, BITS_8, 16'h0000};
    endcase
  endfunction : exp_tx

  function automatic logic [21:0] got_tx(input int s);
    case (s)
      3: return {o_slot3_tx_current, o_slot3_tx_bits, o_slot3_tx_word};
      4: return {o_slot4_tx_current, o_slot4_tx_bits, o_slot4_tx_word};
      default: return {o_slot5_tx_current, o_slot5_tx_bits, o_slot5_tx_word};
    endcase
  endfunction : got_tx

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // register write lands, then decode needs one more edge
  task automatic settle;
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask : settle

  // one apb transfer; waits on pready with a bound
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] wd, input logic [3:0] st,
                     output logic [31:0] rd, output logic er);
    int n;
    // setup phase starts right after an edge
    @(posedge i_clk_sys);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_paddr   <= a;
    i_pwrite  <= w;
    i_pwdata  <= wd;
    i_pstrb   <= st;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    if (o_pready !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
    rd = o_prdata;
    er = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic wr(input int s, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(addr_of(s), 1'b1, {24'h00_0000, d}, 4'hf, r, e);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] x,
                       input logic xe);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b0, 32'h0000_0000, 4'h0, r, e);
    `CHK(r, {24'h00_0000, x})
    `CHK(e, xe)
  endtask : rdchk

  task automatic t_reset;
    settle();
    rdchk(ADDR_SLOT3, 8'h32, 1'b0);
    rdchk(ADDR_SLOT4, 8'h07, 1'b0);
    rdchk(ADDR_SLOT5, 8'h07, 1'b0);
    `CHK({o_play_place, o_play_bits}, {PLACE4, BITS_24})
    `CHK(got_tx(3), exp_tx(3'h2, 3'h3, 1'b0))
    `CHK(got_tx(4), exp_tx(3'h7, 3'h4, 1'b0))
    `CHK(got_tx(5), exp_tx(3'h7, 3'h5, 1'b0))
    $display("test reset done");
  endtask : t_reset

  // every sense code on every slot, reserved bits set high
  task automatic t_sense;
    logic [7:0]  v;
    logic [21:0] x;
    for (int s = 3; s <= 5; s++) begin
      for (int c = 0; c < 8; c++) begin
        {i_volt, i_curr} <= {8'(c), 8'h5a, 8'(s), 8'hc3};
        {i_vbat, i_ctrl_data, i_status} <=
          {8'h11 + 8'(c), 8'h22 + 8'(s), 8'h33 + 8'(c)};
        v = (s == 5) ? {5'h1f, 3'(c)} : {4'hc, 1'b1, 3'(c)};
        wr(s, v);
        settle();
        x = exp_tx(3'(c), 3'(s), 1'b0);
        `CHK(got_tx(s), x)
        rdchk(addr_of(s), v, 1'b0);
      end
    end
    $display("test sense done");
  endtask : t_sense

  task automatic t_alt;
    wr(4, 8'h04);
    settle();
    `CHK(got_tx(4), exp_tx(3'h4, 3'h4, 1'b0))
    i_host.frame();
    settle();
    `CHK(got_tx(4), exp_tx(3'h4, 3'h4, 1'b1))
    i_host.frame();
    settle();
    `CHK(got_tx(4), exp_tx(3'h4, 3'h4, 1'b0))
    $display("test alternation done");
  endtask : t_alt

  // {slot3 width, slot4 width, audio placement, bit count}
  task automatic t_play;
    logic [11:0] tbl [6];
    logic [23:0] d;
    logic [23:0] x;
    logic        hit;
    tbl = '{{2'h0, 2'h1, PLACE3, BITS_24}, {2'h1, 2'h0, PLACE3, BITS_16},
            {2'h2, 2'h1, PLACE4, BITS_16}, {2'h3, 2'h0, PLACE4, BITS_24},
            {2'h2, 2'h3, PLACE_NONE, BITS_0},
            {2'h3, 2'h2, PLACE_NONE, BITS_0}};
    for (int i = 0; i < 6; i++) begin
      wr(3, {2'b00, tbl[i][11:10], 4'h7});
      wr(4, {2'b00, tbl[i][9:8], 4'h7});
      settle();
      `CHK({o_play_place, o_play_bits}, tbl[i][7:0])
      for (int p = 3; p <= 4; p++) begin
        d = {8'(p), 8'(i), 8'h5b};
        hit = (tbl[i][7:5] == 3'(p));
        i_host.send(3'(p), d, i % 3);
        #1;
        `CHK(o_play_valid, hit)
        // a 16-bit word keeps the top two bytes only
        x = (tbl[i][4:0] == BITS_16) ? {d[23:8], 8'h00} : d;
        if (hit) `CHK(o_play_word, x)
        @(posedge i_clk_sys);
        #1;
        `CHK(o_play_valid, 1'b0)
      end
    end
    $display("test playback done");
  endtask : t_play

  // refused accesses, then a second reset in mid-run
  task automatic t_bus;
    logic [31:0] r;
    logic        e;
    rdchk(8'h2c, 8'h00, 1'b1);
    apb(8'h2c, 1'b1, 32'h0000_00ff, 4'hf, r, e);
    `CHK(e, 1'b1)
    apb(ADDR_SLOT5, 1'b1, 32'h0000_0001, 4'he, r, e);
    rdchk(ADDR_SLOT5, 8'hff, 1'b0);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    settle();
    rdchk(ADDR_SLOT3, 8'h32, 1'b0);
    rdchk(ADDR_SLOT5, 8'h07, 1'b0);
    $display("test bus and reset done");
  endtask : t_bus

  // main sequence
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    t_reset();
    t_sense();
    t_alt();
    t_play();
    t_bus();
    tally_and_finish();
  end

  // watchdog in case a task never returns
  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end
endmodule : tb_audio_slot_placement_config
`default_nettype wire
